// ==== qfd_pkg.sv ====
// shared constants and types for the four-wire instruction decoder
package qfd_pkg;
  // opcodes of the four-wire instruction set
  localparam logic [7:0] OP_IDENT = 8'haf;
  localparam logic [7:0] OP_DISC = 8'h5a;
  localparam logic [7:0] OP_FR0 = 8'h0b;
  localparam logic [7:0] OP_FR1 = 8'h6b;
  localparam logic [7:0] OP_FR2 = 8'heb;
  localparam logic [7:0] OP_OTPR = 8'h4b;
  localparam logic [7:0] OP_WLSET = 8'h06;
  localparam logic [7:0] OP_WLCLR = 8'h04;
  localparam logic [7:0] OP_PP0 = 8'h02;
  localparam logic [7:0] OP_PP1 = 8'h32;
  localparam logic [7:0] OP_PP2 = 8'h12;
  localparam logic [7:0] OP_OTPW = 8'h42;
  localparam logic [7:0] OP_SSE = 8'h20;
  localparam logic [7:0] OP_SE = 8'hd8;
  localparam logic [7:0] OP_BE = 8'hc7;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_LOCK_RD = 8'he8;
  localparam logic [7:0] OP_LOCK_WR = 8'he5;
  localparam logic [7:0] OP_FLAG_RD = 8'h70;
  localparam logic [7:0] OP_FLAG_CLR = 8'h50;
  localparam logic [7:0] OP_NV_RD = 8'hb5;
  localparam logic [7:0] OP_NV_WR = 8'hb1;
  localparam logic [7:0] OP_VC_RD = 8'h85;
  localparam logic [7:0] OP_VC_WR = 8'h81;
  localparam logic [7:0] OP_EC_RD = 8'h65;
  localparam logic [7:0] OP_EC_WR = 8'h61;
  localparam logic [7:0] OP_SLP_IN = 8'hb9;
  localparam logic [7:0] OP_SLP_OUT = 8'hab;
  // phase lengths and byte limits
  localparam logic [2:0] ADDR_NIBS = 3'h6;
  localparam logic [3:0] DUMMY_DEF = 4'ha;
  localparam logic [3:0] DISC_DUMMY = 4'h8;
  localparam logic [8:0] ID_BYTES = 9'h003;
  localparam logic [8:0] OTP_MAX = 9'h041;
  localparam logic [8:0] PAGE_MAX = 9'h100;
  localparam logic [8:0] NV_BYTES = 9'h002;
  localparam logic [8:0] CNT_SAT = 9'h1ff;
  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} qfd_dir_e;
  typedef enum logic [1:0] {DUM_NONE, DUM_CFG, DUM_DISC} qfd_dum_e;
  // gray along idle, opcode, address, dummy, data
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0, PH_OPC = 3'h1, PH_ADDR = 3'h3,
    PH_DUMMY = 3'h2, PH_DATA = 3'h6, PH_SKIP = 3'h7
  } qfd_phase_e;
  typedef struct packed {
    logic valid;
    logic addr3;
    qfd_dum_e dum;
    qfd_dir_e dir;
    logic [8:0] dmin;
    logic [8:0] dmax;
    logic chk;
    logic ident;
  } qfd_cmd_s;
endpackage

// ==== qfd_pin_sync.sv ====
// two-stage synchroniser with edge detection for the link pins
`timescale 1ns/1ps
`default_nettype none
module qfd_pin_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins and their synchronised views
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } qfd_sync_s;
  qfd_sync_s st_reg, st_next;

  // shift the pins through three stages; only s2 and s3 are read
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= {INIT, INIT, INIT};
    end else begin
      st_reg <= st_next;
    end
  end

  // levels and edges from the settled stages
  assign lvl = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign fall = ~st_reg.s2 & st_reg.s3;
endmodule
`default_nettype wire

// ==== qfd_op_table.sv ====
// opcode table: address, dummy, direction and byte limits per opcode
`timescale 1ns/1ps
`default_nettype none
module qfd_op_table (
  // opcode in, attributes out
  input wire logic [7:0] opc,
  output qfd_pkg::qfd_cmd_s cmd
);
  function automatic qfd_pkg::qfd_cmd_s mk(
    input logic a3, input qfd_pkg::qfd_dum_e du,
    input qfd_pkg::qfd_dir_e di, input logic [8:0] mn,
    input logic [8:0] mx, input logic ck);
    mk = '{1'b1, a3, du, di, mn, mx, ck, 1'b0};
  endfunction

  // anything not listed stays invalid
  always_comb begin
    cmd = '0;
    case (opc)
      qfd_pkg::OP_IDENT: begin
        cmd = mk(1'b0, qfd_pkg::DUM_NONE, qfd_pkg::DIR_OUT, 9'h001,
                 qfd_pkg::ID_BYTES, 1'b0);
        cmd.ident = 1'b1;
      end
      qfd_pkg::OP_DISC: cmd = mk(1'b1, qfd_pkg::DUM_DISC,
        qfd_pkg::DIR_OUT, 9'h001, 9'h000, 1'b0);
      qfd_pkg::OP_FR0, qfd_pkg::OP_FR1, qfd_pkg::OP_FR2:
        cmd = mk(1'b1, qfd_pkg::DUM_CFG, qfd_pkg::DIR_OUT, 9'h001,
                 9'h000, 1'b0);
      qfd_pkg::OP_OTPR: cmd = mk(1'b1, qfd_pkg::DUM_CFG,
        qfd_pkg::DIR_OUT, 9'h001, qfd_pkg::OTP_MAX, 1'b0);
      qfd_pkg::OP_PP0, qfd_pkg::OP_PP1, qfd_pkg::OP_PP2:
        cmd = mk(1'b1, qfd_pkg::DUM_NONE, qfd_pkg::DIR_IN, 9'h001,
                 qfd_pkg::PAGE_MAX, 1'b1);
      qfd_pkg::OP_OTPW: cmd = mk(1'b1, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_IN, 9'h001, qfd_pkg::OTP_MAX, 1'b1);
      qfd_pkg::OP_SSE, qfd_pkg::OP_SE: cmd = mk(1'b1,
        qfd_pkg::DUM_NONE, qfd_pkg::DIR_NONE, 9'h000, 9'h000, 1'b1);
      qfd_pkg::OP_WLSET, qfd_pkg::OP_WLCLR, qfd_pkg::OP_BE,
      qfd_pkg::OP_RESUME, qfd_pkg::OP_SUSPEND, qfd_pkg::OP_FLAG_CLR:
        cmd = mk(1'b0, qfd_pkg::DUM_NONE, qfd_pkg::DIR_NONE, 9'h000,
                 9'h000, 1'b1);
      qfd_pkg::OP_STAT_RD, qfd_pkg::OP_FLAG_RD, qfd_pkg::OP_VC_RD,
      qfd_pkg::OP_EC_RD: cmd = mk(1'b0, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_OUT, 9'h001, 9'h000, 1'b0);
      qfd_pkg::OP_STAT_WR, qfd_pkg::OP_VC_WR, qfd_pkg::OP_EC_WR:
        cmd = mk(1'b0, qfd_pkg::DUM_NONE, qfd_pkg::DIR_IN, 9'h001,
                 9'h001, 1'b1);
      qfd_pkg::OP_LOCK_RD: cmd = mk(1'b1, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_OUT, 9'h001, 9'h000, 1'b0);
      qfd_pkg::OP_LOCK_WR: cmd = mk(1'b1, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_IN, 9'h001, 9'h001, 1'b1);
      qfd_pkg::OP_NV_RD: cmd = mk(1'b0, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_OUT, qfd_pkg::NV_BYTES, qfd_pkg::NV_BYTES,
        1'b0);
      qfd_pkg::OP_NV_WR: cmd = mk(1'b0, qfd_pkg::DUM_NONE,
        qfd_pkg::DIR_IN, qfd_pkg::NV_BYTES, qfd_pkg::NV_BYTES,
        1'b1);
      qfd_pkg::OP_SLP_IN, qfd_pkg::OP_SLP_OUT: cmd = mk(1'b0,
        qfd_pkg::DUM_NONE, qfd_pkg::DIR_NONE, 9'h000, 9'h000,
        1'b0);
      default: cmd = '0;
    endcase
  end
endmodule
`default_nettype wire

// ==== qfd_decoder.sv ====
// four-wire serial flash instruction decoder, device side
`timescale 1ns/1ps
`default_nettype none
module qfd_decoder #(
  parameter logic [7:0] MFR_ID = 8'h5c, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h1234 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe,
  // device status and settings
  input wire logic prog_busy,
  input wire logic [3:0] dummy_cfg,
  output logic sleeping,
  // executed instruction
  output logic exec,
  output logic reject,
  output logic [7:0] exec_op,
  output logic [23:0] exec_addr,
  // incoming data bytes
  output logic wr_valid,
  output logic [7:0] wr_data,
  // outgoing data bytes
  output logic rd_start,
  output logic rd_next,
  input wire logic [7:0] rd_data
);
  typedef struct packed {
    qfd_pkg::qfd_phase_e phase;
    qfd_pkg::qfd_cmd_s cmd;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [2:0] acnt;
    logic [3:0] dcnt;
    logic [8:0] bytes;
    logic half;
    logic [3:0] lo;
    logic [3:0] dq;
    logic oe;
    logic sleep;
    logic exec;
    logic reject;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_start;
    logic rd_next;
  } qfd_state_s;
  qfd_state_s st_reg, st_next;

  logic [5:0] pin_lvl, pin_rise, pin_fall;
  logic cs_s, cs_rise, cs_fall, sck_rise, sck_fall;
  logic [3:0] dq_s;
  logic [7:0] op_now, id_byte, src;
  logic [3:0] need;
  logic ok;
  qfd_pkg::qfd_cmd_s dec;

  // all pins pass two flip-flops before use
  qfd_pin_sync #(
    .W(6),
    .INIT(6'h20)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({cs_n, sclk, dq_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // synchronised link views
  assign cs_s = pin_lvl[5];
  assign cs_rise = pin_rise[5];
  assign cs_fall = pin_fall[5];
  assign sck_rise = pin_rise[4] & ~cs_s;
  assign sck_fall = pin_fall[4] & ~cs_s;
  assign dq_s = pin_lvl[3:0];
  assign op_now = {st_reg.opc[7:4], dq_s};

  qfd_op_table u_tab (
    .opc(op_now),
    .cmd(dec)
  );

  // dummy length: discovery never below eight full clocks
  always_comb begin
    case (st_reg.cmd.dum)
      qfd_pkg::DUM_CFG: need = dummy_cfg;
      qfd_pkg::DUM_DISC: need = (dummy_cfg < qfd_pkg::DISC_DUMMY) ?
        qfd_pkg::DISC_DUMMY : dummy_cfg;
      default: need = 4'h0;
    endcase
  end

  // ident bytes: maker then two device bytes, no serial code
  always_comb begin
    case (st_reg.bytes[1:0])
      2'h0: id_byte = MFR_ID;
      2'h1: id_byte = DEV_ID[15:8];
      default: id_byte = DEV_ID[7:0];
    endcase
  end
  assign src = st_reg.cmd.ident ? id_byte : rd_data;

  // byte boundary and count check at select rise
  assign ok = !st_reg.cmd.chk || (!st_reg.half &&
    st_reg.bytes >= st_reg.cmd.dmin &&
    st_reg.bytes <= st_reg.cmd.dmax);

  // instruction sequencer
  always_comb begin
    st_next = st_reg;
    st_next.exec = 1'b0;
    st_next.reject = 1'b0;
    st_next.wr_valid = 1'b0;
    st_next.rd_start = 1'b0;
    st_next.rd_next = 1'b0;
    if (cs_rise) begin
      // end of selection: stop driving, go to standby
      st_next.phase = qfd_pkg::PH_IDLE;
      st_next.oe = 1'b0;
      st_next.half = 1'b0;
      if (st_reg.phase == qfd_pkg::PH_DATA &&
          st_reg.cmd.dir != qfd_pkg::DIR_OUT) begin
        if (ok) begin
          st_next.exec = 1'b1;
          if (st_reg.opc == qfd_pkg::OP_SLP_IN) begin
            st_next.sleep = 1'b1;
          end else if (st_reg.opc == qfd_pkg::OP_SLP_OUT) begin
            st_next.sleep = 1'b0;
          end
        end else begin
          st_next.reject = 1'b1;
        end
      end else if (st_reg.phase == qfd_pkg::PH_ADDR &&
                   st_reg.cmd.chk) begin
        st_next.reject = 1'b1;
      end
    end else if (cs_fall) begin
      st_next.phase = qfd_pkg::PH_OPC;
      st_next.half = 1'b0;
      st_next.bytes = 9'h000;
      st_next.oe = 1'b0;
    end else if (!cs_s) begin
      case (st_reg.phase)
        qfd_pkg::PH_OPC: begin
          if (sck_rise && !st_reg.half) begin
            st_next.opc[7:4] = dq_s;
            st_next.half = 1'b1;
          end else if (sck_rise) begin
            st_next.opc = op_now;
            st_next.half = 1'b0;
            st_next.acnt = 3'h0;
            if ((st_reg.sleep && op_now != qfd_pkg::OP_SLP_OUT) ||
                !dec.valid || (dec.ident && prog_busy)) begin
              st_next.phase = qfd_pkg::PH_SKIP;
              st_next.reject = 1'b1;
            end else begin
              st_next.cmd = dec;
              if (dec.addr3) begin
                st_next.phase = qfd_pkg::PH_ADDR;
              end else begin
                st_next.phase = qfd_pkg::PH_DATA;
                st_next.rd_start = dec.dir == qfd_pkg::DIR_OUT &&
                  !dec.ident;
              end
            end
          end
        end
        qfd_pkg::PH_ADDR: begin
          if (sck_rise) begin
            st_next.addr = {st_reg.addr[19:0], dq_s};
            st_next.acnt = st_reg.acnt + 3'h1;
            if (st_reg.acnt == qfd_pkg::ADDR_NIBS - 3'h1) begin
              if (need != 4'h0) begin
                st_next.phase = qfd_pkg::PH_DUMMY;
                st_next.dcnt = need;
              end else begin
                st_next.phase = qfd_pkg::PH_DATA;
                st_next.rd_start = st_reg.cmd.dir == qfd_pkg::DIR_OUT;
              end
            end
          end
        end
        qfd_pkg::PH_DUMMY: begin
          if (sck_rise) begin
            // one full clock per dummy, never compressed
            st_next.dcnt = st_reg.dcnt - 4'h1;
            if (st_reg.dcnt == 4'h1) begin
              st_next.phase = qfd_pkg::PH_DATA;
              st_next.rd_start = 1'b1;
            end
          end
        end
        qfd_pkg::PH_DATA: begin
          if (st_reg.cmd.dir == qfd_pkg::DIR_OUT) begin
            // output high nibble then low on falling edges
            if (sck_fall && !st_reg.half) begin
              if (st_reg.cmd.dmax != 9'h000 &&
                  st_reg.bytes == st_reg.cmd.dmax) begin
                st_next.oe = 1'b0;
              end else begin
                st_next.oe = 1'b1;
                st_next.dq = src[7:4];
                st_next.lo = src[3:0];
                st_next.bytes = st_reg.bytes + 9'h001;
                st_next.half = 1'b1;
                st_next.rd_next = !st_reg.cmd.ident;
              end
            end else if (sck_fall) begin
              st_next.dq = st_reg.lo;
              st_next.half = 1'b0;
            end
          end else if (sck_rise && !st_reg.half) begin
            st_next.lo = dq_s;
            st_next.half = 1'b1;
          end else if (sck_rise) begin
            // pair nibbles into bytes, pass those within limit
            st_next.half = 1'b0;
            if (st_reg.bytes != qfd_pkg::CNT_SAT) begin
              st_next.bytes = st_reg.bytes + 9'h001;
            end
            if (st_reg.bytes < st_reg.cmd.dmax) begin
              st_next.wr_valid = 1'b1;
              st_next.wr_data = {st_reg.lo, dq_s};
            end
          end
        end
        qfd_pkg::PH_SKIP: st_next.oe = 1'b0;
        default: st_next.phase = qfd_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state
  assign dq_out = st_reg.dq;
  assign dq_oe = {4{st_reg.oe}};
  assign sleeping = st_reg.sleep;
  assign exec = st_reg.exec;
  assign reject = st_reg.reject;
  assign exec_op = st_reg.opc;
  assign exec_addr = st_reg.addr;
  assign wr_valid = st_reg.wr_valid;
  assign wr_data = st_reg.wr_data;
  assign rd_start = st_reg.rd_start;
  assign rd_next = st_reg.rd_next;

  // checks on the sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_oe_release: assert property (cs_rise |=> !dq_oe[0])
    else $error("data still driven after select rise");
  a_standby_idle: assert property (
    cs_rise |=> st_reg.phase == qfd_pkg::PH_IDLE)
    else $error("no standby after select rise");
  a_ident_busy: assert property (st_reg.phase == qfd_pkg::PH_OPC &&
    sck_rise && st_reg.half && op_now == qfd_pkg::OP_IDENT &&
    prog_busy && !cs_rise && !cs_fall
    |=> st_reg.phase == qfd_pkg::PH_SKIP)
    else $error("ident decoded while busy");
  a_sleep_ignore: assert property (st_reg.sleep && cs_rise &&
    st_reg.opc != qfd_pkg::OP_SLP_OUT |=> !exec ##1 sleeping)
    else $error("instruction executed in sleep");
  a_sleep_exit: assert property (cs_rise && st_reg.sleep &&
    st_reg.phase == qfd_pkg::PH_DATA &&
    st_reg.opc == qfd_pkg::OP_SLP_OUT |=> exec ##1 !sleeping)
    else $error("sleep exit not executed");
  a_boundary_reject: assert property (cs_rise &&
    st_reg.phase == qfd_pkg::PH_DATA && st_reg.cmd.chk &&
    st_reg.half |=> !exec && reject)
    else $error("partial byte accepted");
  a_unknown_skip: assert property (
    st_reg.phase == qfd_pkg::PH_OPC && sck_rise && st_reg.half &&
    !dec.valid |=> st_reg.phase == qfd_pkg::PH_SKIP && reject)
    else $error("unknown opcode not refused");
  a_ident_limit: assert property (st_reg.cmd.ident &&
    st_reg.phase == qfd_pkg::PH_DATA |->
    st_reg.bytes <= qfd_pkg::ID_BYTES)
    else $error("ident gave more than three bytes");
  a_disc_dummy: assert property (
    st_next.phase == qfd_pkg::PH_DUMMY &&
    st_reg.phase == qfd_pkg::PH_ADDR &&
    st_reg.cmd.dum == qfd_pkg::DUM_DISC |=>
    st_reg.dcnt >= qfd_pkg::DISC_DUMMY)
    else $error("discovery dummy below eight");
  a_cfg_dummy: assert property (st_reg.phase == qfd_pkg::PH_ADDR &&
    st_next.phase == qfd_pkg::PH_DUMMY &&
    st_reg.cmd.dum == qfd_pkg::DUM_CFG
    |=> st_reg.dcnt == $past(dummy_cfg))
    else $error("dummy not from setting");
  a_oe_in_data: assert property (dq_oe[0] |->
    st_reg.phase == qfd_pkg::PH_DATA ||
    $past(st_reg.phase) == qfd_pkg::PH_DATA)
    else $error("driving outside data phase");
  a_wr_cap: assert property (wr_valid |->
    st_reg.bytes <= st_reg.cmd.dmax)
    else $error("write byte beyond limit");

  c_exec: cover property (exec && !sleeping);
  c_ident_out: cover property (st_reg.cmd.ident && dq_oe[0]);
  c_sleep: cover property ($rose(sleeping));
  c_read: cover property (rd_start ##[1:200] rd_next);
endmodule
`default_nettype wire

// ==== qfd_host_model.sv ====
// host-side four-wire controller model: select, serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module qfd_host_model (
  // system clock used to pace the link
  input wire logic clk,
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe
);
  logic [4:0] rx[$]; // oe flag and nibble seen at each read clock

  // idle link: deselected, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'h0;
  end

  // wait on falling system clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one frame: send tx nibbles, then clock rx_n nibbles back
  task automatic xfer(input logic [3:0] tx[$], input int rx_n);
    rx.delete();
    cs_n = 1'b0;
    tick(4);
    for (int k = 0; k < tx.size() + rx_n; k++) begin
      if (k < tx.size())
        dq_in = tx[k];
      else
        dq_in = ~dq_in; // released lines hold no stale value
      tick(4);
      sclk = 1'b1;
      if (k >= tx.size())
        rx.push_back({dq_oe[0], dq_out});
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    dq_in = ~dq_in;
    tick(8);
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the four-wire instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] MFR = 8'h9e; // arbitrary value
  localparam logic [15:0] DEV = 16'h4d21; // arbitrary value
  localparam logic [23:0] AD = 24'h7e5a31;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prog_busy = 1'b0;
  logic [3:0] dummy_cfg = 4'ha;
  logic [7:0] rd_data = 8'h00;
  logic sclk, cs_n, sleeping, exec, reject, wr_valid, rd_start, rd_next;
  logic [3:0] dq_in, dq_out, dq_oe;
  logic [7:0] exec_op, wr_data, last_wr;
  logic [23:0] exec_addr;
  int bad_count = 0;
  int compares = 0;
  int ec = 0, jc = 0, wc = 0, sc = 0, cyc = 0;

  qfd_decoder #(.MFR_ID(MFR), .DEV_ID(DEV)) dut_u (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .prog_busy(prog_busy), .dummy_cfg(dummy_cfg), .sleeping(sleeping),
    .exec(exec), .reject(reject), .exec_op(exec_op), .exec_addr(exec_addr),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_start(rd_start),
    .rd_next(rd_next), .rd_data(rd_data));
  qfd_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));

  // 20 MHz system clock
  always #25 clk = ~clk;

  // count result pulses and keep the last written byte
  always @(posedge clk) begin
    cyc++;
    if (exec === 1'b1) ec++;
    if (reject === 1'b1) jc++;
    if (rd_start === 1'b1) sc++;
    if (wr_valid === 1'b1) begin
      wc++;
      last_wr = wr_data;
    end
    if (cyc == 40000) begin
      bad_count++;
      $display("[FAIL] %0t run timed out", $time);
      stop_test();
    end
  end

  // read source: counts up from 3ch, one step per consumed byte
  always @(negedge clk) begin
    if (rd_start === 1'b1) rd_data <= 8'h3c;
    else if (rd_next === 1'b1) rd_data <= rd_data + 8'h01;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic res(input int e, input int j, input int w, input int s);
    chk(ec, e, "exec pulses");
    chk(jc, j, "reject pulses");
    chk(wc, w, "bytes received");
    chk(sc, s, "read starts");
  endtask

  function automatic logic [7:0] wbyte(input int j);
    return j[7:0] ^ 8'h5a;
  endfunction

  // frame: opcode, an address nibbles, dn dummies, wn data nibbles, rn reads
  task automatic run(input logic [7:0] op, input int an, input int dn,
    input int wn, input int rn);
    logic [3:0] q[$];
    logic [7:0] b;
    q = {op[7:4], op[3:0]};
    for (int i = 0; i < an; i++) q.push_back(AD[23-4*i -: 4]);
    for (int i = 0; i < dn; i++) q.push_back(4'hf);
    for (int i = 0; i < wn; i++) begin
      b = wbyte(i / 2);
      q.push_back(i[0] ? b[3:0] : b[7:4]);
    end
    ec = 0;
    jc = 0;
    wc = 0;
    sc = 0;
    host_u.xfer(q, rn);
  endtask

  // identification read: full, cut short, and while busy
  task automatic t_ident();
    logic [23:0] id;
    id = {MFR, DEV};
    run(qfd_pkg::OP_IDENT, 0, 0, 0, 8);
    for (int k = 0; k < 6; k++)
      chk(host_u.rx[k], {1'b1, id[23-4*k -: 4]}, "ident nibble");
    chk(host_u.rx[6][4], 1'b0, "ident past three bytes");
    res(0, 0, 0, 0);
    run(qfd_pkg::OP_IDENT, 0, 0, 0, 3);
    chk(dq_oe, 4'h0, "drive after select rise");
    prog_busy = 1'b1;
    run(qfd_pkg::OP_IDENT, 0, 0, 0, 4);
    chk(host_u.rx[1][4], 1'b0, "ident while busy");
    res(0, 1, 0, 0);
    prog_busy = 1'b0;
  endtask

  // read with dn dummies; output off from nibble lim on
  task automatic t_read(input logic [7:0] op, input int an, input int dn,
    input int cfg, input int n, input int lim);
    logic [7:0] b;
    dummy_cfg = cfg[3:0];
    run(op, an, dn, 0, n);
    res(0, 0, 0, 1);
    chk(exec_op, op, "read opcode");
    if (an > 0)
      chk(exec_addr, AD, "read address");
    for (int k = 0; k < n; k++) begin
      b = 8'h3c + k[8:1];
      if (k < lim)
        chk(host_u.rx[k], {1'b1, k[0] ? b[3:0] : b[7:4]}, "data");
      else
        chk(host_u.rx[k][4], 1'b0, "drive past limit");
    end
  endtask

  // write of wn nibbles: accepted or refused, wb bytes passed on
  task automatic t_write(input logic [7:0] op, input int an, input int wn,
    input int ok, input int wb);
    run(op, an, 0, wn, 0);
    res(ok, 1 - ok, wb, 0);
    if (ok == 1) begin
      chk(exec_op, op, "write opcode");
      if (an > 0)
        chk(exec_addr, AD, "write address");
      if (wn > 1)
        chk(last_wr, wbyte(wn / 2 - 1), "last byte");
    end
  endtask

  // sleep: only the exit opcode is decoded
  task automatic t_sleep();
    run(qfd_pkg::OP_SLP_IN, 0, 0, 0, 0);
    res(1, 0, 0, 0);
    chk(sleeping, 1'b1, "asleep");
    run(qfd_pkg::OP_WLSET, 0, 0, 0, 0);
    res(0, 1, 0, 0);
    run(qfd_pkg::OP_IDENT, 0, 0, 0, 2);
    chk(host_u.rx[1][4], 1'b0, "ident in sleep");
    res(0, 1, 0, 0);
    run(qfd_pkg::OP_SLP_OUT, 0, 0, 0, 0);
    res(1, 0, 0, 0);
    chk(sleeping, 1'b0, "awake");
  endtask

  // reset in mid-run: leaves sleep, drops outputs, decodes again
  task automatic t_reset();
    run(qfd_pkg::OP_SLP_IN, 0, 0, 0, 0);
    res(1, 0, 0, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(sleeping, 1'b0, "sleep after reset");
    chk(dq_oe, 4'h0, "drive after reset");
    chk(exec_op, 8'h00, "opcode after reset");
    run(qfd_pkg::OP_WLSET, 0, 0, 0, 0);
    res(1, 0, 0, 0);
  endtask

  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(dq_oe, 4'h0, "reset drive");
    chk(exec_op, 8'h00, "reset opcode");
    t_ident();
    t_read(qfd_pkg::OP_FR0, 6, 10, 10, 6, 99);
    t_read(qfd_pkg::OP_FR1, 6, 10, 10, 6, 99);
    t_read(qfd_pkg::OP_FR2, 6, 3, 3, 6, 99);
    t_read(qfd_pkg::OP_DISC, 6, 8, 4, 6, 99);
    t_read(qfd_pkg::OP_OTPR, 6, 5, 5, 132, 130);
    t_read(qfd_pkg::OP_FLAG_RD, 0, 0, 10, 6, 99);
    t_read(qfd_pkg::OP_NV_RD, 0, 0, 10, 6, 4);
    t_read(qfd_pkg::OP_VC_RD, 0, 0, 10, 6, 99);
    t_read(qfd_pkg::OP_EC_RD, 0, 0, 10, 6, 99);
    t_write(qfd_pkg::OP_PP0, 6, 2, 1, 1);
    t_write(qfd_pkg::OP_PP1, 6, 512, 1, 256);
    t_write(qfd_pkg::OP_PP2, 6, 4, 1, 2);
    t_write(qfd_pkg::OP_OTPW, 6, 130, 1, 65);
    t_write(qfd_pkg::OP_FLAG_CLR, 0, 0, 1, 0);
    t_write(qfd_pkg::OP_NV_WR, 0, 4, 1, 2);
    t_write(qfd_pkg::OP_VC_WR, 0, 2, 1, 1);
    t_write(qfd_pkg::OP_EC_WR, 0, 2, 1, 1);
    t_write(qfd_pkg::OP_LOCK_WR, 6, 2, 1, 1);
    t_read(qfd_pkg::OP_LOCK_RD, 6, 0, 10, 6, 99);
    t_read(qfd_pkg::OP_STAT_RD, 0, 0, 10, 6, 99);
    t_write(qfd_pkg::OP_STAT_WR, 0, 2, 1, 1);
    t_write(qfd_pkg::OP_SSE, 6, 0, 1, 0);
    t_write(qfd_pkg::OP_SE, 3, 0, 0, 0);
    t_write(qfd_pkg::OP_BE, 0, 0, 1, 0);
    t_write(qfd_pkg::OP_SUSPEND, 0, 0, 1, 0);
    t_write(qfd_pkg::OP_RESUME, 0, 0, 1, 0);
    t_write(qfd_pkg::OP_WLSET, 0, 2, 0, 0);
    t_write(qfd_pkg::OP_WLCLR, 0, 0, 1, 0);
    t_write(qfd_pkg::OP_PP0, 6, 3, 0, 1);
    t_write(qfd_pkg::OP_PP0, 6, 0, 0, 0);
    t_write(qfd_pkg::OP_OTPW, 6, 132, 0, 65);
    t_write(qfd_pkg::OP_NV_WR, 0, 2, 0, 1);
    t_write(qfd_pkg::OP_VC_WR, 0, 4, 0, 1);
    t_write(8'hff, 0, 6, 0, 0);
    t_sleep();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
